// ==== logic/spip_pkg.sv ====
package spip_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_MAIN = 6'h00;
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_IRQEN = 6'h02;
    localparam logic [5:0] IDX_FLAGS = 6'h03;
    localparam logic [5:0] IDX_DATA = 6'h04;
    // Main control fields.
    localparam int MAIN_ORDER = 6;
    localparam int MAIN_HOST = 5;
    localparam int MAIN_DBL = 4;
    localparam int MAIN_DIV = 1;
    localparam int MAIN_EN = 0;
    // Mode control fields.
    localparam int MODE_BUF = 7;
    localparam int MODE_BWR = 6;
    localparam int MODE_SSD = 2;
    localparam int MODE_XM = 0;
    // Interrupt enable fields.
    localparam int IE_RXC = 7;
    localparam int IE_TXC = 6;
    localparam int IE_DRE = 5;
    localparam int IE_SS = 4;
    localparam int IE_NORM = 0;
    // Flag fields, normal and buffer layout.
    localparam int FL_IF = 7;
    localparam int FL_WCOL = 6;
    localparam int FL_RXC = 7;
    localparam int FL_TXC = 6;
    localparam int FL_DRE = 5;
    localparam int FL_SS = 4;
    localparam int FL_OVF = 0;
    // Writable bits and values after reset.
    localparam logic [7:0] MAIN_MASK = 8'h77;
    localparam logic [7:0] MODE_MASK = 8'hc7;
    localparam logic [7:0] IE_MASK = 8'hf1;
    localparam logic [7:0] IE_NORM_MASK = 8'h01;
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_IRQEN = 8'h00;
    // Serial clock divisors of the peripheral clock.
    localparam logic [7:0] DIVIDE_BY_FOUR = 8'h04;
    localparam logic [7:0] DIVIDE_BY_SIXTEEN = 8'h10;
    localparam logic [7:0] DIVIDE_BY_SIXTYFOUR = 8'h40;
    localparam logic [7:0] DIVIDE_BY_ONETWENTYEIGHT = 8'h80;
    localparam logic [3:0] EDGE_LAST = 4'hf;
    localparam logic [1:0] RX_DEPTH = 2'h2;
    typedef enum logic [1:0] {
        SP_IDLE = 2'b01,
        SP_SHIFT = 2'b10
    } spip_state_t;
endpackage

// ==== logic/spip_ctrl.sv ====
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
// Operation
// - Bit order control set sends least significant bit first, clear sends most first.
// - Role select bit clear means client, set means host.
// - Host with select input low clears role bit and sets transfer-complete flag, or the select flag in buffer mode.
// - Select-disable bit keeps host mode despite a low select pin.
// - Doubler bit doubles the host serial clock after the prescaler.
// - Prescaler codes divide the peripheral clock by 4, 16, 64, 128 in host mode.
// - Enable bit clear disables the interface, set enables it.
// - Buffer mode adds two receive stages and one transmit stage with flags.
// - Without wait-for-receive, a client completes one transfer first, sending a dummy byte.
// - With wait-for-receive, first write while enabled and deselected loads shifter.
// - Transfer mode code selects which clock edge samples and which sets up.
// - Serial clock idles low for rising leading edge, high for falling.
// - Buffer interrupt enables act only in buffer mode, else read zero.
// - Normal interrupt enable requests on transfer complete outside buffer mode.
// - Normal transfer-complete flag sets after a full byte is shifted.
// - Transfer flag clears on vector taken, or flag read then data access.
// - Write collision sets on data write mid-byte; clears by read then access.
// - Interrupt request stays active while a flag and its enable are set.
// - Normal mode data writes load shifter; reads return received byte.
// - Client with select high resets the transfer and discards its data.
module spip_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic ssIn,
    input wire logic ssIsInput,
    // Interrupt
    input wire logic vectorTaken,
    output logic irqReq
);
    function automatic logic [6:0] halfPeriod(input logic [1:0] sel, input logic dbl);
        logic [7:0] d;
        case (sel)
            2'h0: d = spip_pkg::DIVIDE_BY_FOUR;
            2'h1: d = spip_pkg::DIVIDE_BY_SIXTEEN;
            2'h2: d = spip_pkg::DIVIDE_BY_SIXTYFOUR;
            default: d = spip_pkg::DIVIDE_BY_ONETWENTYEIGHT;
        endcase
        halfPeriod = dbl ? {1'b0, d[7:2]} : d[7:1];
    endfunction

    function automatic logic bitAt(input logic [7:0] b, input logic [2:0] i, input logic lsb);
        bitAt = lsb ? b[i] : b[3'h7 - i];
    endfunction

    function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic d, input logic lsb);
        shiftIn = lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    logic [7:0] mainCtl, modeCtl, ieCtl, ieView, flagByte, next_rdData;
    logic lsbFirst, hostMode, enabled, bufMode, bufWait, ssDis, cpol, cpha;
    logic wbReq, wrByte, wrMain, wrMode, wrIe, wrFlags, rdFlags, dataWr, dataRd, dataAcc;
    logic [5:0] idx;
    spip_pkg::spip_state_t state;
    logic busy, clientSel, hostDrop, sckEdge, sampleEdge, setupEdge, doneEvt, inBit;
    logic [3:0] edgeCnt;
    logic [6:0] halfCnt, halfVal;
    logic [2:0] setupIdx;
    logic [7:0] shTx, rxSh, rxFinal, rxData, txBuf, rxBuf0, rxBuf1, loadData;
    logic outBit, sckPrev, loadEvt, normLoad, bufCopy, bufDirect, bufWrite;
    logic txFull, primed, shPending, push, pop;
    logic [1:0] rxCount;
    logic ifFlag, write_collision_flag, ifArm, wcArm, txcFlag, ssFlag, ovfFlag, next_irq;

    assign lsbFirst = mainCtl[spip_pkg::MAIN_ORDER];
    assign hostMode = mainCtl[spip_pkg::MAIN_HOST];
    assign enabled = mainCtl[spip_pkg::MAIN_EN];
    assign bufMode = modeCtl[spip_pkg::MODE_BUF];
    assign bufWait = modeCtl[spip_pkg::MODE_BWR];
    assign ssDis = modeCtl[spip_pkg::MODE_SSD];
    assign cpol = modeCtl[spip_pkg::MODE_XM + 1];
    assign cpha = modeCtl[spip_pkg::MODE_XM];

    // Bus decode; side effects fire once, in the cycle before the acknowledge.
    assign idx = wb_adr_i[7:2];
    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrByte = wbReq & wb_we_i & wb_sel_i[0];
    assign wrMain = wrByte && idx == spip_pkg::IDX_MAIN;
    assign wrMode = wrByte && idx == spip_pkg::IDX_MODE;
    assign wrIe = wrByte && idx == spip_pkg::IDX_IRQEN;
    assign wrFlags = wrByte && idx == spip_pkg::IDX_FLAGS;
    assign rdFlags = wbReq && !wb_we_i && idx == spip_pkg::IDX_FLAGS;
    assign dataWr = wrByte && idx == spip_pkg::IDX_DATA;
    assign dataRd = wbReq && !wb_we_i && idx == spip_pkg::IDX_DATA;
    assign dataAcc = wbReq && idx == spip_pkg::IDX_DATA;

    // Serial engine decode.
    assign busy = state == spip_pkg::SP_SHIFT;
    assign clientSel = enabled & ~hostMode & ~ssIn;
    assign hostDrop = enabled & hostMode & ssIsInput & ~ssDis & ~ssIn;
    assign halfVal = halfPeriod(mainCtl[spip_pkg::MAIN_DIV +: 2], mainCtl[spip_pkg::MAIN_DBL]);
    assign sckEdge = hostMode ? (busy && halfCnt == halfVal - 7'h1) : (clientSel && sckIn != sckPrev);
    assign sampleEdge = sckEdge & (~edgeCnt[0] ^ cpha);
    assign setupEdge = sckEdge & ~(~edgeCnt[0] ^ cpha);
    assign setupIdx = edgeCnt[3:1] + {2'b00, ~cpha};
    assign doneEvt = hostMode ? (sckEdge && edgeCnt == spip_pkg::EDGE_LAST)
                              : (sampleEdge && edgeCnt[3:1] == 3'h7);
    assign inBit = hostMode ? misoIn : mosiIn;
    assign rxFinal = sampleEdge ? shiftIn(rxSh, inBit, lsbFirst) : rxSh;

    // Loading the shifter: direct in normal mode, through the transmit stage in buffer mode except the first wait-for-receive write.
    assign normLoad = dataWr & ~bufMode & ~busy;
    assign bufDirect = dataWr & bufMode & bufWait & enabled & ssIn & ~primed & ~busy;
    assign bufCopy = bufMode & enabled & ~busy & txFull & (hostMode | (primed & ~shPending));
    assign bufWrite = dataWr & bufMode & ~txFull & ~bufDirect;
    assign loadEvt = normLoad | bufCopy | bufDirect;
    assign loadData = bufCopy ? txBuf : wb_dat_i[7:0];
    assign push = doneEvt & bufMode;
    assign pop = dataRd & bufMode & (rxCount != 2'h0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mainCtl <= spip_pkg::RST_MAIN;
        end else if (wrMain) begin
            mainCtl <= wb_dat_i[7:0] & spip_pkg::MAIN_MASK;
        end else if (hostDrop) begin
            mainCtl[spip_pkg::MAIN_HOST] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            modeCtl <= spip_pkg::RST_MODE;
            ieCtl <= spip_pkg::RST_IRQEN;
        end else begin
            if (wrMode) begin
                modeCtl <= wb_dat_i[7:0] & spip_pkg::MODE_MASK;
            end
            if (wrIe) begin
                ieCtl <= wb_dat_i[7:0] & spip_pkg::IE_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !enabled) begin
            state <= spip_pkg::SP_IDLE;
        end else begin
            case (state)
                spip_pkg::SP_IDLE: begin
                    if (hostMode ? (loadEvt && !hostDrop) : (sckEdge && edgeCnt == 4'h0)) begin
                        state <= spip_pkg::SP_SHIFT;
                    end
                end
                spip_pkg::SP_SHIFT: begin
                    if (doneEvt || hostDrop || (!hostMode && !clientSel)) begin
                        state <= spip_pkg::SP_IDLE;
                    end
                end
                default: state <= spip_pkg::SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !enabled || (!hostMode && ssIn) || (hostMode && !busy)) begin
            edgeCnt <= 4'h0;
        end else if (sckEdge) begin
            edgeCnt <= edgeCnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !busy || !hostMode || sckEdge) begin
            halfCnt <= 7'h00;
        end else begin
            halfCnt <= halfCnt + 7'h01;
        end
    end

    // Pin drivers; the clock returns to its idle level whenever no byte is in flight.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sckOut <= 1'b0;
            sckOe <= 1'b0;
            mosiOe <= 1'b0;
            misoOe <= 1'b0;
            sckPrev <= 1'b0;
        end else begin
            if (!busy || !hostMode) begin
                sckOut <= cpol;
            end else if (sckEdge) begin
                sckOut <= ~sckOut;
            end
            sckOe <= enabled & hostMode;
            mosiOe <= enabled & hostMode;
            misoOe <= clientSel;
            sckPrev <= sckIn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            outBit <= 1'b0;
        end else if (loadEvt) begin
            outBit <= bitAt(loadData, 3'h0, lsbFirst);
        end else if (setupEdge) begin
            outBit <= bitAt(shTx, setupIdx, lsbFirst);
        end else if (!busy) begin
            outBit <= bitAt(shTx, 3'h0, lsbFirst);
        end
    end
    assign mosiOut = outBit;
    assign misoOut = outBit;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shTx <= 8'h00;
            rxSh <= 8'h00;
            rxData <= 8'h00;
        end else begin
            if (loadEvt) begin
                shTx <= loadData;
            end
            if (sampleEdge) begin
                rxSh <= rxFinal;
            end
            if (doneEvt && !bufMode) begin
                rxData <= rxFinal;
            end
        end
    end

    // Buffer mode staging.
    always_ff @(posedge clk_sys) begin
        if (rst || !bufMode) begin
            txFull <= 1'b0;
            txBuf <= 8'h00;
        end else if (bufWrite) begin
            txFull <= 1'b1;
            txBuf <= wb_dat_i[7:0];
        end else if (bufCopy) begin
            txFull <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !bufMode || !enabled) begin
            primed <= 1'b0;
            shPending <= 1'b0;
        end else begin
            if (doneEvt || bufDirect) begin
                primed <= 1'b1;
            end
            if (loadEvt) begin
                shPending <= 1'b1;
            end else if (doneEvt) begin
                shPending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !bufMode) begin
            rxCount <= 2'h0;
        end else if (push && !pop && rxCount != spip_pkg::RX_DEPTH) begin
            rxCount <= rxCount + 2'h1;
        end else if (pop && !push) begin
            rxCount <= rxCount - 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxBuf0 <= 8'h00;
            rxBuf1 <= 8'h00;
        end else if (pop) begin
            rxBuf0 <= (push && rxCount == 2'h1) ? rxFinal : rxBuf1;
            if (push) begin
                rxBuf1 <= rxFinal;
            end
        end else if (push && rxCount == 2'h0) begin
            rxBuf0 <= rxFinal;
        end else if (push && rxCount == 2'h1) begin
            rxBuf1 <= rxFinal;
        end
    end

    // Flags; a setting event always beats a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ifFlag <= 1'b0;
            write_collision_flag <= 1'b0;
            ifArm <= 1'b0;
            wcArm <= 1'b0;
        end else begin
            if ((doneEvt || hostDrop) && !bufMode) begin
                ifFlag <= 1'b1;
            end else if (vectorTaken || (ifArm && dataAcc)) begin
                ifFlag <= 1'b0;
            end
            if (dataWr && !bufMode && busy) begin
                write_collision_flag <= 1'b1;
            end else if (wcArm && dataAcc) begin
                write_collision_flag <= 1'b0;
            end
            if (rdFlags) begin
                ifArm <= ifFlag;
                wcArm <= write_collision_flag;
            end else if (dataAcc) begin
                ifArm <= 1'b0;
                wcArm <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txcFlag <= 1'b0;
            ssFlag <= 1'b0;
            ovfFlag <= 1'b0;
        end else begin
            if (push && !txFull) begin
                txcFlag <= 1'b1;
            end else if (wrFlags && wb_dat_i[spip_pkg::FL_TXC]) begin
                txcFlag <= 1'b0;
            end
            if (hostDrop && bufMode) begin
                ssFlag <= 1'b1;
            end else if (wrFlags && wb_dat_i[spip_pkg::FL_SS]) begin
                ssFlag <= 1'b0;
            end
            if (push && !pop && rxCount == spip_pkg::RX_DEPTH) begin
                ovfFlag <= 1'b1;
            end else if (dataRd || (wrFlags && wb_dat_i[spip_pkg::FL_OVF])) begin
                ovfFlag <= 1'b0;
            end
        end
    end

    // Buffer enables are held but hidden and inert outside buffer mode.
    assign ieView = bufMode ? ieCtl : (ieCtl & spip_pkg::IE_NORM_MASK);

    always_comb begin
        if (bufMode) begin
            next_irq = (ieView[spip_pkg::IE_RXC] & (rxCount != 2'h0)) | (ieView[spip_pkg::IE_TXC] & txcFlag)
                     | (ieView[spip_pkg::IE_DRE] & ~txFull) | (ieView[spip_pkg::IE_SS] & ssFlag);
        end else begin
            next_irq = ieView[spip_pkg::IE_NORM] & ifFlag;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqReq <= 1'b0;
        end else begin
            irqReq <= next_irq;
        end
    end

    always_comb begin
        flagByte = 8'h00;
        if (bufMode) begin
            flagByte[spip_pkg::FL_RXC] = rxCount != 2'h0;
            flagByte[spip_pkg::FL_TXC] = txcFlag;
            flagByte[spip_pkg::FL_DRE] = ~txFull;
            flagByte[spip_pkg::FL_SS] = ssFlag;
            flagByte[spip_pkg::FL_OVF] = ovfFlag;
        end else begin
            flagByte[spip_pkg::FL_IF] = ifFlag;
            flagByte[spip_pkg::FL_WCOL] = write_collision_flag;
        end
        case (idx)
            spip_pkg::IDX_MAIN: next_rdData = mainCtl;
            spip_pkg::IDX_MODE: next_rdData = modeCtl;
            spip_pkg::IDX_IRQEN: next_rdData = ieView;
            spip_pkg::IDX_FLAGS: next_rdData = flagByte;
            spip_pkg::IDX_DATA: next_rdData = bufMode ? rxBuf0 : rxData;
            default: next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            if (wbReq) begin
                wb_dat_o <= {24'h00_0000, next_rdData};
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_host_drop_flag: assert property (hostDrop && !bufMode && !wrMain |=> !hostMode && ifFlag)
        else $error("Select low in host mode did not drop to client with flag set.");
    a_select_override: assert property (enabled && hostMode && ssDis && !ssIn && !wrMain |=> hostMode)
        else $error("Host mode lost although select override was disabled.");
    a_sck_idle_level: assert property ($past(!busy) && $stable(cpol) |-> sckOut == cpol)
        else $error("Serial clock not at its idle level between transfers.");
    a_divide_by_four_rate: assert property (hostMode && busy && halfVal == 7'h02 && $changed(sckOut) |=> $stable(sckOut))
        else $error("Serial clock toggled faster than the divide-by-four rate.");
    a_double_rate: assert property (hostMode && busy && $past(busy) && $stable(mainCtl) && halfVal == 7'h01
                                    |-> $changed(sckOut))
        else $error("Doubled clock did not toggle every cycle.");
    a_write_collision_flag_set: assert property (dataWr && !bufMode && busy |=> write_collision_flag && $stable(shTx))
        else $error("Mid-byte data write did not flag a collision.");
    a_done_flag: assert property (doneEvt && !bufMode
                                  |=> ifFlag ##1 (ifFlag || $past(ifArm && dataAcc || vectorTaken)))
        else $error("Completed byte did not set the transfer flag.");
    a_irq_normal: assert property (!bufMode && ieCtl[spip_pkg::IE_NORM] && ifFlag |=> irqReq)
        else $error("Normal interrupt not requested with flag and enable set.");
    a_client_reset: assert property (enabled && !hostMode && ssIn |=> !busy && edgeCnt == 4'h0)
        else $error("Deselected client kept transfer state.");
    a_disabled_quiet: assert property (!enabled |=> !busy && !sckOe && !mosiOe && !misoOe)
        else $error("Disabled interface still active on its pins.");
    a_ie_hidden: assert property (wb_ack_o && $past(idx == spip_pkg::IDX_IRQEN && !wb_we_i && !bufMode)
                                  |-> wb_dat_o[7:4] == 4'h0)
        else $error("Buffer interrupt enables visible outside buffer mode.");

    c_host_byte: cover property (doneEvt && hostMode);
    c_client_byte: cover property (doneEvt && !hostMode);
    c_host_drop: cover property (hostDrop);
    c_rx_overflow: cover property (push && !pop && rxCount == spip_pkg::RX_DEPTH);
endmodule

// ==== sim/spip_client_model.sv ====
`timescale 1ns/1ns
module spip_client_model (
    // Serial side
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    output logic miso,
    // Setup and capture
    input wire logic [1:0] mode,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    logic [7:0] sh;
    int edges;
    initial begin
        miso = 1'b0;
        rxByte = 8'h00;
        sh = 8'h00;
        edges = 0;
    end
    // A released line shows the inverse of its last bit, so a stale value never passes.
    always @(posedge selN) begin
        miso = ~miso;
    end
    // Even modes present the first bit at selection.
    always @(negedge selN) begin
        sh = txByte;
        edges = 0;
        if (!mode[0]) begin
            miso = sh[7];
            sh = sh << 1;
        end
    end
    // Odd edge counts are leading edges, counted from the idle level.
    always @(sck) begin
        if (!selN) begin
            edges = edges + 1;
            if ((edges[0] ^ mode[0]) == 1'b1) begin
                rxByte = {rxByte[6:0], mosi};
            end else begin
                miso = sh[7];
                sh = sh << 1;
            end
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    logic clk_sys, rst, cyc, stb, we, ack, ssIn, ssIsInput, selN, sckOut, mosiOut, miso, irqReq, vecTk;
    logic [7:0] adr, mTx, mRx;
    logic [1:0] mMode;
    logic [31:0] datI, datO;
    int nFail, checks;
    spip_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .sckIn(1'b0), .sckOut(sckOut), .sckOe(), .mosiIn(1'b0), .mosiOut(mosiOut), .mosiOe(),
        .misoIn(miso), .misoOut(), .misoOe(), .ssIn(ssIn), .ssIsInput(ssIsInput),
        .vectorTaken(vecTk), .irqReq(irqReq));
    spip_client_model peer_u (.sck(sckOut), .mosi(mosiOut), .selN(selN), .miso(miso), .mode(mMode),
        .txByte(mTx), .rxByte(mRx));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= {24'h000000, d};
        do begin
            @(negedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({7'h00, ack}, 8'h01);
        @(posedge clk_sys);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic waitIrq();
        int n;
        n = 0;
        while (irqReq !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, irqReq}, 8'h01);
        @(posedge clk_sys);
    endtask
    task automatic regs();
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h77);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'hc7);
        wr(8'h08, 8'hff);
        rd(8'h08, 8'hf1);
        wr(8'h04, 8'h00);
        rd(8'h08, 8'h01);
        wr(8'h14, 8'h5a);
        rd(8'h14, 8'h00);
    endtask
    task automatic xfer(input logic [7:0] m, md, tx, mt, er, em, input int hp);
        int n;
        logic s;
        mMode <= md[1:0];
        mTx <= mt;
        wr(8'h04, md);
        wr(8'h00, m);
        selN <= 1'b0;
        @(negedge clk_sys);
        chk({7'h00, sckOut}, {7'h00, md[1]});
        @(posedge clk_sys);
        wr(8'h10, tx);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (sckOut === md[1] && n < 300);
        s = sckOut;
        n = 0;
        while (sckOut === s && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk(8'(n), 8'(hp));
        waitIrq();
        rd(8'h0c, 8'h80);
        rd(8'h10, er);
        chk(mRx, em);
        rd(8'h0c, 8'h00);
        @(negedge clk_sys);
        chk({7'h00, irqReq}, 8'h00);
        @(posedge clk_sys);
        selN <= 1'b1;
    endtask
    task automatic collide();
        wr(8'h00, 8'h20);
        wr(8'h10, 8'h55);
        repeat (40) @(posedge clk_sys);
        rd(8'h0c, 8'h00);
        mMode <= 2'b00;
        mTx <= 8'h5a;
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h21);
        selN <= 1'b0;
        wr(8'h10, 8'h11);
        wr(8'h10, 8'h22);
        waitIrq();
        rd(8'h0c, 8'hc0);
        rd(8'h10, 8'h5a);
        rd(8'h0c, 8'h00);
        selN <= 1'b1;
    endtask
    task automatic drop();
        wr(8'h00, 8'h21);
        ssIsInput <= 1'b1;
        ssIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(8'h00, 8'h01);
        rd(8'h0c, 8'h80);
        vecTk <= 1'b1;
        @(posedge clk_sys);
        vecTk <= 1'b0;
        rd(8'h0c, 8'h00);
        // With select-disable set, a host keeps its role while the select input is low.
        ssIn <= 1'b1;
        wr(8'h04, 8'h04);
        wr(8'h00, 8'h21);
        ssIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(8'h00, 8'h21);
        ssIn <= 1'b1;
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // The longest transfer takes just over 512 cycles; this limit is more than ten times the whole run.
    initial begin
        #800000;
        nFail++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        datI = 32'h00000000;
        ssIn = 1'b1;
        ssIsInput = 1'b0;
        selN = 1'b1;
        mTx = 8'h00;
        mMode = 2'b00;
        vecTk = 1'b0;
        nFail = 0;
        checks = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        regs();
        xfer(8'h21, 8'h00, 8'ha5, 8'h3c, 8'h3c, 8'ha5, 2);
        xfer(8'h25, 8'h01, 8'h96, 8'h69, 8'h69, 8'h96, 32);
        xfer(8'h37, 8'h02, 8'h0f, 8'he1, 8'he1, 8'h0f, 32);
        xfer(8'h73, 8'h03, 8'h12, 8'hc4, 8'h23, 8'h48, 4);
        xfer(8'h31, 8'h01, 8'h3c, 8'hc3, 8'hc3, 8'h3c, 1);
        collide();
        drop();
        test_done();
    end
endmodule
